// ===== rtl/pms_sequencer.sv
// power mode sequencer: reset, standby, sleep, active, radio
//
// Contract
// - External reset forces Reset with every regulator, clock and RF off.
// - After reset the boot sequence reaches Active within 1.5, 7 or 94 ms by low-speed source.
// - Sleep runs exactly one low-speed oscillator, with high speed, core and RF off and state kept.
// - An option powers off the second memory bank in Sleep while the rest stays retained.
// - In Sleep an expired wake timer leads to Active within 0.42 ms.
// - Host SPI activity (select low) also wakes Sleep to Active.
// - Standby is Sleep with both low-speed oscillators off, woken only by SPI, in 0.42 or 6.2 ms.
// - Waking from Standby with the low-speed crystal completes within 93 ms.
// - Active powers supplies, interfaces, high-speed oscillator and core, with all RF off.
// - Radio adds the synthesizer and exactly one of the receive or transmit chains.
// - Active to receive takes 125 us with a channel change and 61 us without.
// - Active to transmit takes 131 us with change (67 us without); turnaround takes 150 us.
// - Host commands arrive on an SPI slave port clocked up to 8 MHz.
// - The command set includes firmware reprogramming beside stack services.
// - In low-power states all SPI pins except select are high impedance.
// - The attention output shows that data waits for the host to read.
`timescale 1ns/1ps
`default_nettype none

module pms_sequencer #(
  parameter int unsigned T_BOOT_NOLS = pms_pkg::T_RESET_NOLS_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_BOOT_RO   = pms_pkg::T_RESET_RO_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_BOOT_XO   = pms_pkg::T_RESET_XO_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_WAKE_NOLS = pms_pkg::T_STBY_NOLS_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_WAKE_RO   = pms_pkg::T_STBY_RO_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_WAKE_XO   = pms_pkg::T_STBY_XO_US
                                       * pms_pkg::CYC_PER_US,
  parameter int unsigned T_WAKE_SLP  = pms_pkg::T_SLEEP_US
                                       * pms_pkg::CYC_PER_US
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [1:0]           ls_source,
  input  wire pms_pkg::pms_fw_req_s fw_req,
  input  wire logic                 wake_timer_expired,
  input  wire logic                 slave_select_low_n,
  input  wire logic                 spi_miso_data,
  input  wire logic                 host_data_pending,
  output var  pms_pkg::pms_power_s  power,
  output var  pms_pkg::pms_spi_pad_s spi_pad,
  output var  pms_pkg::pms_state_e  state,
  output logic                      busy
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  pms_pkg::pms_state_e       next_state;
  logic [pms_pkg::CNT_W-1:0] cnt;
  logic [pms_pkg::CNT_W-1:0] next_cnt;
  logic                      cnt_done;
  logic                      bank2_off;
  logic                      in_rx;
  logic                      next_in_rx;
  logic                      radio_ready;
  logic                      wake_req;
  logic                      low_power;

  function automatic logic [pms_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = (n > 1) ? pms_pkg::CNT_W'(n - 1) : '0;
  endfunction : cyc

  assign cnt_done  = (cnt == '0);
  assign wake_req  = ~slave_select_low_n
                   | (wake_timer_expired & (ls_source != pms_pkg::LS_NONE));
  assign low_power = (next_state == pms_pkg::PMS_SLEEP)
                   | (next_state == pms_pkg::PMS_STANDBY);
  assign busy      = (state != pms_pkg::PMS_ACTIVE)
                   & ~((state == pms_pkg::PMS_RADIO) & radio_ready);

  ////////////////////////////////////////////////////////////////////////
  // next state and timer load
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt_done ? cnt : cnt - 1'b1;
    next_in_rx = in_rx;
    case (state)
      pms_pkg::PMS_RESET:
      begin
        next_state = pms_pkg::PMS_BOOT;
        case (ls_source)
          pms_pkg::LS_RING: next_cnt = cyc(T_BOOT_RO);
          pms_pkg::LS_XTAL: next_cnt = cyc(T_BOOT_XO);
          default:          next_cnt = cyc(T_BOOT_NOLS);
        endcase
      end
      pms_pkg::PMS_BOOT:
        if (cnt_done)
          next_state = pms_pkg::PMS_ACTIVE;
      pms_pkg::PMS_ACTIVE:
        if (fw_req.sleep_req | fw_req.standby_req)
          next_state = pms_pkg::PMS_ENTRY;
        else if (fw_req.rx_req | fw_req.tx_req)
        begin
          next_state = pms_pkg::PMS_RADIO;
          next_in_rx = fw_req.rx_req;
          if (fw_req.rx_req)
            next_cnt = fw_req.chan_change ? cyc(pms_pkg::CYC_RX_CHG)
                                          : cyc(pms_pkg::CYC_RX_NOCHG);
          else
            next_cnt = fw_req.chan_change ? cyc(pms_pkg::CYC_TX_CHG)
                                          : cyc(pms_pkg::CYC_TX_NOCHG);
        end
      pms_pkg::PMS_ENTRY:
        if (wake_req)
          next_state = pms_pkg::PMS_ACTIVE;
        else if (fw_req.standby_req)
          next_state = pms_pkg::PMS_STANDBY;
        else if (ls_source != pms_pkg::LS_NONE)
          next_state = pms_pkg::PMS_SLEEP;
        else
          next_state = pms_pkg::PMS_STANDBY;
      pms_pkg::PMS_SLEEP:
        if (wake_req)
        begin
          next_state = pms_pkg::PMS_WAKE;
          next_cnt   = cyc(T_WAKE_SLP);
        end
      pms_pkg::PMS_STANDBY:
        if (~slave_select_low_n)
        begin
          next_state = pms_pkg::PMS_WAKE;
          case (ls_source)
            pms_pkg::LS_RING: next_cnt = cyc(T_WAKE_RO);
            pms_pkg::LS_XTAL: next_cnt = cyc(T_WAKE_XO);
            default:          next_cnt = cyc(T_WAKE_NOLS);
          endcase
        end
      pms_pkg::PMS_WAKE:
        if (cnt_done)
          next_state = pms_pkg::PMS_ACTIVE;
      pms_pkg::PMS_RADIO:
        if (fw_req.radio_off)
          next_state = pms_pkg::PMS_ACTIVE;
        else if ((fw_req.rx_req & ~in_rx) | (fw_req.tx_req & in_rx))
        begin
          next_in_rx = ~in_rx;
          next_cnt   = cyc(pms_pkg::CYC_TURN);
        end
      default:
        next_state = pms_pkg::PMS_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state <= pms_pkg::PMS_RESET;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      in_rx <= 1'b0;
    else
      in_rx <= next_in_rx;
  end

  // radio settled once its settle count runs out
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      radio_ready <= 1'b0;
    else if (next_state != pms_pkg::PMS_RADIO || next_in_rx != in_rx
             || state != pms_pkg::PMS_RADIO)
      radio_ready <= 1'b0;
    else if (cnt_done)
      radio_ready <= 1'b1;
  end

  // bank option latched at entry
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      bank2_off <= 1'b0;
    else if (state == pms_pkg::PMS_ACTIVE)
      bank2_off <= fw_req.bank2_off;
  end

  ////////////////////////////////////////////////////////////////////////
  // power enables, registered from the next state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      power <= '0;
    else
    begin
      power <= '0;
      case (next_state)
        pms_pkg::PMS_RESET:
          power <= '0;
        pms_pkg::PMS_SLEEP, pms_pkg::PMS_STANDBY:
        begin
          power.regulator_on <= 1'b1;
          power.retain       <= 1'b1;
          power.spi_on       <= 1'b1;
          power.second_memory_bank_on <= ~bank2_off;
          if (next_state == pms_pkg::PMS_SLEEP)
          begin
            power.ls_xtal_on <= (ls_source == pms_pkg::LS_XTAL);
            power.ls_ring_on <= (ls_source == pms_pkg::LS_RING);
          end
        end
        default:
        begin
          power.regulator_on             <= 1'b1;
          power.retain                   <= 1'b1;
          power.spi_on                   <= 1'b1;
          power.second_memory_bank_on    <= 1'b1;
          power.high_speed_oscillator_on <= 1'b1;
          power.core_on                  <= 1'b1;
          power.ls_xtal_on <= (ls_source == pms_pkg::LS_XTAL);
          power.ls_ring_on <= (ls_source == pms_pkg::LS_RING);
          if (next_state == pms_pkg::PMS_RADIO)
          begin
            power.rf_synth_on <= 1'b1;
            power.rx_chain_on <= next_in_rx;
            power.tx_chain_on <= ~next_in_rx;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // spi pads: miso driven only while selected and awake
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      spi_pad <= '0;
    else
    begin
      spi_pad.miso_out <= spi_miso_data;
      spi_pad.miso_oe  <= ~low_power & ~slave_select_low_n
                        & (next_state != pms_pkg::PMS_RESET);
      spi_pad.attn_out <= host_data_pending & ~low_power;
      spi_pad.attn_oe  <= ~low_power
                        & (next_state != pms_pkg::PMS_RESET);
    end
  end

endmodule : pms_sequencer

`default_nettype wire

// ===== rtl/pms_pkg.sv
// package: power mode sequencer constants and types
package pms_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 20000000;

  // activation and wake times, microseconds (max times, round down)
  localparam int unsigned T_RESET_NOLS_US   = 1500;
  localparam int unsigned T_RESET_RO_US     = 7000;
  localparam int unsigned T_RESET_XO_US     = 94000;
  localparam int unsigned T_STBY_NOLS_US    = 420;
  localparam int unsigned T_STBY_RO_US      = 6200;
  localparam int unsigned T_STBY_XO_US      = 93000;
  localparam int unsigned T_SLEEP_US        = 420;
  // radio times, nanoseconds
  localparam int unsigned T_RX_CHG_NS       = 125000;
  localparam int unsigned T_RX_NOCHG_NS     = 61000;
  localparam int unsigned T_TX_CHG_NS       = 131000;
  localparam int unsigned T_TX_NOCHG_NS     = 67000;
  localparam int unsigned T_TURN_NS         = 150000;

  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;

  localparam int unsigned CYC_RX_CHG   = T_RX_CHG_NS * CYC_PER_US / 1000;
  localparam int unsigned CYC_RX_NOCHG = T_RX_NOCHG_NS * CYC_PER_US / 1000;
  localparam int unsigned CYC_TX_CHG   = T_TX_CHG_NS * CYC_PER_US / 1000;
  localparam int unsigned CYC_TX_NOCHG = T_TX_NOCHG_NS * CYC_PER_US / 1000;
  localparam int unsigned CYC_TURN     = T_TURN_NS * CYC_PER_US / 1000;

  localparam int unsigned CNT_W = 21;

  // low-speed clock source selection
  localparam logic [1:0] LS_NONE = 2'h0;
  localparam logic [1:0] LS_RING = 2'h1;
  localparam logic [1:0] LS_XTAL = 2'h2;

  typedef enum logic [7:0] {
    PMS_RESET   = 8'h01,
    PMS_BOOT    = 8'h02,
    PMS_ACTIVE  = 8'h04,
    PMS_ENTRY   = 8'h08,
    PMS_SLEEP   = 8'h10,
    PMS_STANDBY = 8'h20,
    PMS_WAKE    = 8'h40,
    PMS_RADIO   = 8'h80
  } pms_state_e;

  // power and clock enables toward the analog and digital domains
  typedef struct packed {
    logic regulator_on;
    logic retain;
    logic spi_on;
    logic ls_xtal_on;
    logic ls_ring_on;
    logic high_speed_oscillator_on;
    logic core_on;
    logic rf_synth_on;
    logic rx_chain_on;
    logic tx_chain_on;
    logic second_memory_bank_on;
  } pms_power_s;

  // firmware requests
  typedef struct packed {
    logic sleep_req;
    logic standby_req;
    logic bank2_off;
    logic rx_req;
    logic tx_req;
    logic chan_change;
    logic radio_off;
  } pms_fw_req_s;

  // spi pad group: outputs with enables
  typedef struct packed {
    logic miso_out;
    logic miso_oe;
    logic attn_out;
    logic attn_oe;
  } pms_spi_pad_s;

endpackage : pms_pkg

// ===== verif/pms_sva.sv
// checker: power mode sequencer assertions
`timescale 1ns/1ps
`default_nettype none
module pms_sva #(
  parameter int T_WK = 20
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  slave_select_low_n,
  input wire pms_pkg::pms_power_s   power,
  input wire pms_pkg::pms_spi_pad_s spi_pad,
  input wire pms_pkg::pms_state_e   state
);
  localparam int WK = T_WK + 2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  reset_off_a: assert property (
    state == pms_pkg::PMS_RESET |-> power == '0) else $error("power in reset");
  sleep_osc_a: assert property (
    state == pms_pkg::PMS_SLEEP |-> (power.ls_xtal_on ^ power.ls_ring_on)
    && !power.high_speed_oscillator_on && !power.core_on && power.retain)
    else $error("sleep power wrong");
  standby_pwr_a: assert property (
    state == pms_pkg::PMS_STANDBY |-> !power.ls_xtal_on && !power.ls_ring_on
    && !power.high_speed_oscillator_on && power.retain)
    else $error("standby power wrong");
  active_pwr_a: assert property (
    state == pms_pkg::PMS_ACTIVE |-> power.high_speed_oscillator_on
    && power.core_on && power.spi_on && !power.rf_synth_on
    && !power.rx_chain_on && !power.tx_chain_on) else $error("active power");
  radio_one_a: assert property (
    state == pms_pkg::PMS_RADIO |-> power.rf_synth_on
    && (power.rx_chain_on ^ power.tx_chain_on)) else $error("radio chains");
  select_wake_a: assert property (
    state == pms_pkg::PMS_SLEEP && !slave_select_low_n
    |=> state == pms_pkg::PMS_WAKE) else $error("select did not wake");
  wake_time_a: assert property (
    $rose(state == pms_pkg::PMS_WAKE) |-> ##[1:WK] state == pms_pkg::PMS_ACTIVE)
    else $error("wake too slow");
  pads_off_a: assert property (
    state inside {pms_pkg::PMS_SLEEP, pms_pkg::PMS_STANDBY}
    |-> !spi_pad.miso_oe && !spi_pad.attn_oe) else $error("pad driven");
endmodule : pms_sva
`default_nettype wire

// ===== verif/pms_host_model.sv
// host spi master model: select as wake request
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
  input  wire logic clk_sys,
  input  wire logic go,
  output logic      slave_select_low_n
);
  logic [2:0] cnt = 3'h0;
  always @(posedge clk_sys)
  begin
    if (go && cnt == 3'h0)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  // released select is driven high whenever the count is zero
  assign slave_select_low_n = (cnt == 3'h0);
endmodule : pms_host_model
`default_nettype wire

// ===== verif/testbench.sv
// testbench: power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] ls; logic sb; logic tm; logic b2; pms_pkg::pms_state_e st;
  } pms_row_s;
  logic                  clk_sys = 1'b0;
  logic                  rst_n   = 1'b0;
  logic [1:0]            ls      = 2'h0;
  pms_pkg::pms_fw_req_s  fw      = '0;
  logic                  tmr     = 1'b0;
  logic                  go      = 1'b0;
  logic                  miso    = 1'b0;
  logic                  pend    = 1'b1;
  localparam int         T_FAST  = 20;
  logic                  ssn;
  pms_pkg::pms_power_s   pw;
  pms_pkg::pms_spi_pad_s pad;
  pms_pkg::pms_state_e   st;
  logic                  busy;
  int                    failures  = 0;
  int                    cmp_count = 0;
  int                    n;
  int                    m;
  pms_row_s rows [6] = '{'{2'h1, 1'b0, 1'b1, 1'b0, pms_pkg::PMS_SLEEP},
    '{2'h2, 1'b0, 1'b0, 1'b1, pms_pkg::PMS_SLEEP},
    '{2'h1, 1'b1, 1'b0, 1'b0, pms_pkg::PMS_STANDBY},
    '{2'h0, 1'b0, 1'b0, 1'b0, pms_pkg::PMS_STANDBY},
    '{2'h2, 1'b1, 1'b0, 1'b1, pms_pkg::PMS_STANDBY},
    '{2'h0, 1'b1, 1'b0, 1'b0, pms_pkg::PMS_STANDBY}};
  logic [6:0] rq [4] = '{7'h0a, 7'h08, 7'h06, 7'h04};
  int         cy [4] = '{2500, 1220, 2620, 1340};
  always #25 clk_sys = ~clk_sys;
  pms_sequencer #(.T_BOOT_NOLS(T_FAST), .T_WAKE_NOLS(T_FAST),
    .T_WAKE_RO(T_FAST), .T_WAKE_XO(T_FAST), .T_WAKE_SLP(T_FAST)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ls_source(ls), .fw_req(fw),
    .wake_timer_expired(tmr), .slave_select_low_n(ssn), .spi_miso_data(miso),
    .host_data_pending(pend), .power(pw), .spi_pad(pad), .state(st),
    .busy(busy));
  pms_host_model host (.clk_sys(clk_sys), .go(go), .slave_select_low_n(ssn));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_st(input pms_pkg::pms_state_e s, output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (st !== s && c < 5000);
    if (st !== s)
    begin
      failures++;
      summarize();
    end
  endtask : wait_st
  task automatic settle(output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (busy !== 1'b0 && c < 4000);
    if (busy !== 1'b0)
    begin
      failures++;
      summarize();
    end
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_st(pms_pkg::PMS_BOOT, n);
    wait_st(pms_pkg::PMS_ACTIVE, n);
    chk("boot", n, T_FAST);
    $display("boot done");
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      ls <= rows[i].ls;
      fw <= {!rows[i].sb, rows[i].sb, rows[i].b2, 4'h0};
      wait_st(rows[i].st, n);
      chk("bank", pw.second_memory_bank_on, !rows[i].b2);
      chk("xtal", pw.ls_xtal_on, rows[i].st[4] && ls == 2'h2);
      chk("ring", pw.ls_ring_on, rows[i].st[4] && ls == 2'h1);
      @(posedge clk_sys);
      fw <= '0;
      tmr <= rows[i].tm | rows[i].st[5];
      go <= !rows[i].tm && rows[i].st[4];
      if (rows[i].st[5])
      begin
        repeat (30) @(posedge clk_sys);
        #1;
        chk("timer", st, pms_pkg::PMS_STANDBY);
        @(posedge clk_sys);
        go <= 1'b1;
      end
      wait_st(pms_pkg::PMS_WAKE, n);
      chk("wake req", n <= 2, 1);
      wait_st(pms_pkg::PMS_ACTIVE, n);
      chk("wake", n, T_FAST);
      go <= 1'b0;
      tmr <= 1'b0;
      chk("attn", {pad.attn_out, pad.attn_oe}, 2'h3);
      $display("row %0d done", i);
    end
    repeat (5) @(posedge clk_sys);
    fw <= 7'h40;
    go <= 1'b1;
    miso <= 1'b1;
    pend <= 1'b0;
    wait_st(pms_pkg::PMS_ENTRY, n);
    @(posedge clk_sys);
    #1;
    chk("entry wake", st, pms_pkg::PMS_ACTIVE);
    chk("miso", {pad.miso_out, pad.miso_oe}, 2'h3);
    chk("attn low", pad.attn_out, 1'b0);
    fw <= '0;
    go <= 1'b0;
    $display("entry wake done");
    foreach (rq[i])
    begin
      @(posedge clk_sys);
      fw <= rq[i];
      settle(m);
      chk("settle", m <= cy[i] + 2, 1);
      chk("chain", pw.rx_chain_on, rq[i][3]);
      fw <= rq[i][3] ? 7'h04 : 7'h08;
      settle(m);
      chk("turn", m <= 3002, 1);
      chk("turn chain", pw.tx_chain_on, rq[i][3]);
      fw <= 7'h01;
      wait_st(pms_pkg::PMS_ACTIVE, n);
      fw <= '0;
      $display("radio %0d done", i);
    end
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    chk("reset", {pw, pad, st}, {15'h0, 8'h01});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_st(pms_pkg::PMS_ACTIVE, n);
    chk("reboot", n, T_FAST + 1);
    $display("reset done");
    summarize();
  end
endmodule : testbench
bind pms_sequencer pms_sva u_sva (.clk_sys(clk_sys),
  .rst_n(rst_n), .slave_select_low_n(slave_select_low_n), .power(power),
  .spi_pad(spi_pad), .state(state));
`default_nettype wire
